// file: design/hscan_pkg.sv
package hscan_pkg;
   // Clock and bit timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MAX_BAUD = 1000000;
   localparam int MIN_BIT_NS = 1000000000 / MAX_BAUD;
   localparam int MIN_BIT_CYC = (MIN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Mode change settle time, nominal default
   localparam int MODE_TIME_NS = 20000;
   localparam int MODE_CYC = (MODE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   // Pin levels
   localparam logic PIN_LOW = 1'b0;
   localparam logic PIN_HIGH = 1'b1;
   localparam logic BIT_RECESSIVE = 1'b1;

   typedef enum logic [1:0] {
      HSC_STANDBY = 2'b00,
      HSC_NORMAL = 2'b01,
      HSC_RXONLY = 2'b10
   } hsc_mode_t;
endpackage

// file: design/hscan_ctrl.sv
module hscan_ctrl #(
   parameter int BIT_CYC = hscan_pkg::MIN_BIT_CYC,
   parameter int MODE_WAIT_CYC = hscan_pkg::MODE_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [1:0] i_mode,
   input wire logic i_mode_valid,
   output logic o_mode_ready,
   output logic [1:0] o_mode,
   input wire logic i_tx_bit,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   output logic o_rx_bit,
   output logic o_rx_valid,
   output logic o_bit_error,
   output logic o_txd,
   input wire logic i_rxd,
   output logic o_receive_only_select_n,
   output logic o_standby_select_n
);
   localparam logic [hscan_pkg::CNT_W-1:0] BIT_LAST = hscan_pkg::CNT_W'(BIT_CYC - 1);
   localparam logic [hscan_pkg::CNT_W-1:0] MODE_LOAD = hscan_pkg::CNT_W'(MODE_WAIT_CYC);

   // Refuse settings the counters or the bus rate cannot serve, at elaboration
   if (BIT_CYC < hscan_pkg::MIN_BIT_CYC || BIT_CYC >= (1 << hscan_pkg::CNT_W)) begin : g_bad_bit
      $error("BIT_CYC out of range");
   end
   if (MODE_WAIT_CYC < 1 || MODE_WAIT_CYC >= (1 << hscan_pkg::CNT_W)) begin : g_bad_mode
      $error("MODE_WAIT_CYC out of range");
   end

   logic rst_s1_q;
   logic rst_s2_q;
   logic rst_n;
   hscan_pkg::hsc_mode_t mode_q;
   logic [hscan_pkg::CNT_W-1:0] mode_cnt_q;
   logic [hscan_pkg::CNT_W-1:0] bit_cnt_q;
   logic txd_q;
   logic sent_q;
   logic rx_bit_q;
   logic rx_valid_q;
   logic err_q;
   logic slot_end;
   logic tx_take;
   logic mode_take;
   logic mode_ok;

   // Reset release through two flip-flops
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // Mode requests taken only when the previous change has settled
   assign mode_take = i_mode_valid && (mode_cnt_q == '0) &&
      (i_mode == 2'h0 || i_mode == 2'h1 || i_mode == 2'h2);
   assign mode_ok = (mode_cnt_q == '0);
   assign o_mode_ready = mode_ok;
   assign o_mode = mode_q;

   // Current mode and settle timer, stand-by after reset
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= hscan_pkg::HSC_STANDBY;
         mode_cnt_q <= '0;
      end else if (mode_take) begin
         mode_q <= hscan_pkg::hsc_mode_t'(i_mode);
         mode_cnt_q <= MODE_LOAD;
      end else if (mode_cnt_q != '0) begin
         mode_cnt_q <= mode_cnt_q - 16'h0001;
      end
   end

   // Mode select pins, registered
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_standby_select_n <= hscan_pkg::PIN_HIGH;
         o_receive_only_select_n <= hscan_pkg::PIN_HIGH;
      end else begin
         case (mode_q)
            hscan_pkg::HSC_NORMAL: begin
               o_standby_select_n <= hscan_pkg::PIN_LOW;
               o_receive_only_select_n <= hscan_pkg::PIN_HIGH;
            end
            hscan_pkg::HSC_RXONLY: begin
               o_standby_select_n <= hscan_pkg::PIN_LOW;
               o_receive_only_select_n <= hscan_pkg::PIN_LOW;
            end
            default: begin
               o_standby_select_n <= hscan_pkg::PIN_HIGH;
               o_receive_only_select_n <= hscan_pkg::PIN_HIGH;
            end
         endcase
      end
   end

   // Free-running bit slot timer
   assign slot_end = (bit_cnt_q == '0);
   assign o_tx_ready = slot_end && mode_ok && (mode_q == hscan_pkg::HSC_NORMAL);
   assign tx_take = o_tx_ready && i_tx_valid;

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_q <= '0;
      end else if (slot_end) begin
         bit_cnt_q <= BIT_LAST;
      end else begin
         bit_cnt_q <= bit_cnt_q - 16'h0001;
      end
   end

   // Transmit pin changes only at slot edges; idle slots are recessive
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         txd_q <= hscan_pkg::BIT_RECESSIVE;
         sent_q <= 1'b0;
      end else if (slot_end) begin
         txd_q <= tx_take ? i_tx_bit : hscan_pkg::BIT_RECESSIVE;
         sent_q <= tx_take;
      end
   end
   assign o_txd = txd_q;

   // Receive pin sampled at slot end and compared with the sent bit
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_bit_q <= hscan_pkg::BIT_RECESSIVE;
         rx_valid_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         rx_valid_q <= slot_end && sent_q;
         if (slot_end && sent_q) begin
            rx_bit_q <= i_rxd;
            err_q <= (i_rxd != txd_q);
         end
      end
   end
   assign o_rx_bit = rx_bit_q;
   assign o_rx_valid = rx_valid_q;
   assign o_bit_error = err_q;

   // Cycles since the transmit pin last changed, saturating
   logic [hscan_pkg::CNT_W-1:0] hold_q;
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= '1;
      end else if (txd_q != $past(txd_q)) begin
         hold_q <= '0;
      end else if (hold_q != '1) begin
         hold_q <= hold_q + 16'h0001;
      end
   end

   property p_bit_rate;
      @(posedge i_clk) disable iff (!rst_n)
         $changed(txd_q) |-> (hold_q >= BIT_LAST);
   endproperty
   a_bit_rate: assert property (p_bit_rate) else $error("transmit bit too short");

   property p_ready_settled;
      @(posedge i_clk) disable iff (!rst_n)
         (mode_cnt_q != '0) |-> !o_tx_ready;
   endproperty
   a_ready_settled: assert property (p_ready_settled) else $error("ready before settle");

   sequence s_mode_taken;
      mode_take;
   endsequence
   sequence s_settle_wait;
      !o_mode_ready [*8];
   endsequence
   property p_settle_held;
      @(posedge i_clk) disable iff (!rst_n)
         s_mode_taken |=> s_settle_wait;
   endproperty
   a_settle_held: assert property (p_settle_held) else $error("settle time cut short");

   property p_idle_release;
      @(posedge i_clk) disable iff (!rst_n)
         (slot_end && !tx_take) |=> (txd_q == hscan_pkg::BIT_RECESSIVE);
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("idle slot not recessive");

   property p_standby_pins;
      @(posedge i_clk) disable iff (!rst_n)
         (mode_q == hscan_pkg::HSC_STANDBY) |=> o_standby_select_n && o_receive_only_select_n;
   endproperty
   a_standby_pins: assert property (p_standby_pins) else $error("stand-by pins wrong");

   property p_no_tx_outside_normal;
      @(posedge i_clk) disable iff (!rst_n)
         (mode_q != hscan_pkg::HSC_NORMAL) && slot_end |=> txd_q;
   endproperty
   a_no_tx_outside_normal: assert property (p_no_tx_outside_normal) else $error("sent outside normal");

   property p_compare;
      @(posedge i_clk) disable iff (!rst_n)
         (slot_end && sent_q) |=> o_rx_valid && (o_bit_error == (o_rx_bit != $past(txd_q)));
   endproperty
   a_compare: assert property (p_compare) else $error("bit compare wrong");

   property p_normal_pins;
      @(posedge i_clk) disable iff (!rst_n)
         (mode_q == hscan_pkg::HSC_NORMAL) |=> !o_standby_select_n && o_receive_only_select_n;
   endproperty
   a_normal_pins: assert property (p_normal_pins) else $error("normal pins wrong");

   // Receive-only pulls both select pins low
   property p_rxonly_pins;
      @(posedge i_clk) disable iff (!rst_n)
         (mode_q == hscan_pkg::HSC_RXONLY) |=> !o_standby_select_n && !o_receive_only_select_n;
   endproperty
   a_rxonly_pins: assert property (p_rxonly_pins) else $error("receive-only pins wrong");

   // The unused code never changes the selected mode
   property p_code_refused;
      @(posedge i_clk) disable iff (!rst_n)
         (i_mode_valid && (i_mode == 2'h3)) |=> (o_mode == $past(o_mode));
   endproperty
   a_code_refused: assert property (p_code_refused) else $error("unused mode code taken");
endmodule // hscan_ctrl

// file: tb/hscan_xcvr_model.sv
module hscan_xcvr_model #(
   parameter int TO_CYC = 250
) (
   input wire logic i_clk,
   input wire logic i_txd,
   input wire logic i_receive_only_select_n,
   input wire logic i_standby_select_n,
   input wire logic i_other_dom,
   input wire logic i_hot,
   input wire logic i_low_vcc,
   output logic o_rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic norm, rx_on, drive;
   logic lock_q = 1'b0;
   int cnt_q = 0;
   // Mode decode, open pins read high; low supply forces stand-by
   assign rx_on = !i_low_vcc && (i_standby_select_n === 1'b0);
   assign norm = rx_on && (i_receive_only_select_n !== 1'b0);
   // Dominant time-out, released by a high transmit level
   always_ff @(posedge i_clk) begin
      cnt_q <= (norm && !i_txd) ? cnt_q + 1 : 0;
      lock_q <= i_txd ? 1'b0 : (lock_q || cnt_q > TO_CYC);
   end
   // Bus level and receive pin
   assign drive = norm && !i_txd && !lock_q && !i_hot;
   assign o_rxd = rx_on ? !(drive || i_other_dom) : 1'b1;
endmodule // hscan_xcvr_model

// file: tb/hscan_ctrl_test.sv
module hscan_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MW = 20;
   logic clk, nrst, mode_valid, tx_bit, tx_valid, other_dom, hot, uv, b, d;
   logic [1:0] mode;
   logic o_mode_ready, o_tx_ready, o_rx_bit, o_rx_valid, o_bit_error, o_txd, rxd, nrm_n, nen_n;
   logic [1:0] o_mode;
   int bad_count = 0;
   int cmp_count = 0;
   int k;
   hscan_ctrl #(.BIT_CYC(100), .MODE_WAIT_CYC(MW)) u_dut (.i_clk(clk), .i_nrst(nrst),
      .i_mode(mode), .i_mode_valid(mode_valid), .o_mode_ready(o_mode_ready), .o_mode(o_mode),
      .i_tx_bit(tx_bit), .i_tx_valid(tx_valid), .o_tx_ready(o_tx_ready), .o_rx_bit(o_rx_bit),
      .o_rx_valid(o_rx_valid), .o_bit_error(o_bit_error), .o_txd(o_txd), .i_rxd(rxd),
      .o_receive_only_select_n(nrm_n), .o_standby_select_n(nen_n));
   hscan_xcvr_model u_xcvr (.i_clk(clk), .i_txd(o_txd), .i_receive_only_select_n(nrm_n),
      .i_standby_select_n(nen_n), .i_other_dom(other_dom), .i_hot(hot), .i_low_vcc(uv),
      .o_rxd(rxd));
   // Clock
   always #5 clk = ~clk;
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait for a high level, seen at the falling edge
   task automatic wait_hi(ref logic s, input int lim);
      int n;
      for (n = 0; n <= lim; n++) begin
         @(negedge clk);
         if (s === 1'b1) break;
      end
      if (n > lim) begin
         bad_count++;
         end_sim();
      end
   endtask
   // Select pin pair {receive-only, stand-by} for a mode
   function automatic logic [1:0] pins(input logic [1:0] m);
      return (m == 2'h1) ? 2'h2 : ((m == 2'h2) ? 2'h0 : 2'h3);
   endfunction
   task automatic set_mode(input logic [1:0] m, input logic [1:0] exp);
      @(posedge clk);
      mode <= m;
      mode_valid <= 1'b1;
      wait_hi(o_mode_ready, 5000);
      @(posedge clk);
      mode_valid <= 1'b0;
      repeat (MW + 4) @(posedge clk);
      @(negedge clk);
      chk(o_mode, exp);
      chk({nrm_n, nen_n}, pins(exp));
   endtask
   task automatic send_bit(input logic bv, input logic dv, input logic exp);
      @(posedge clk);
      tx_bit <= bv;
      tx_valid <= 1'b1;
      wait_hi(o_tx_ready, 300);
      @(posedge clk);
      tx_valid <= 1'b0;
      other_dom <= dv;
      wait_hi(o_rx_valid, 300);
      chk(o_rx_bit, exp);
      chk(o_bit_error, exp != bv);
   endtask
   // Main sequence
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      mode = 2'h0;
      mode_valid = 1'b0;
      tx_bit = 1'b1;
      tx_valid = 1'b0;
      other_dom = 1'b0;
      hot = 1'b0;
      uv = 1'b0;
      k = $urandom(32'h472310a7);
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({nrm_n, nen_n}, 2'h3);
      chk({o_txd, o_mode[0]}, 2'h2);
      set_mode(2'h3, 2'h0);
      set_mode(2'h2, 2'h2);
      k = 0;
      repeat (300) begin
         @(negedge clk);
         k += (o_tx_ready !== 1'b0);
      end
      chk({1'b0, (k != 0)}, 2'h0);
      set_mode(2'h1, 2'h1);
      repeat (20) begin
         b = 1'($urandom);
         d = 1'($urandom);
         send_bit(b, d, b & ~d);
      end
      // Held dominant stream runs into the time-out
      @(posedge clk);
      other_dom <= 1'b0;
      tx_bit <= 1'b0;
      tx_valid <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         wait_hi(o_rx_valid, 300);
         chk(o_rx_bit, (i == 2));
      end
      @(posedge clk);
      tx_valid <= 1'b0;
      wait_hi(o_rx_valid, 300);
      send_bit(1'b0, 1'b0, 1'b0);
      @(posedge clk);
      hot <= 1'b1;
      send_bit(1'b0, 1'b0, 1'b1);
      @(posedge clk);
      hot <= 1'b0;
      send_bit(1'b0, 1'b0, 1'b0);
      // Low supply: stand-by, receive pin recessive even with a dominant bus
      @(posedge clk);
      uv <= 1'b1;
      send_bit(1'b0, 1'b1, 1'b1);
      @(posedge clk);
      uv <= 1'b0;
      send_bit(1'b0, 1'b0, 1'b0);
      set_mode(2'h0, 2'h0);
      end_sim();
   end
endmodule // hscan_ctrl_test
